// [pkg/cfl_pkg.sv]
// Purpose: constants and types of the channel fault latch block
// Assumes: 10 MHz clock, eight channels, AXI4-Lite register access
// Notes:   register byte address = {bank, index, 2'b00}
// Behaviour
// - Overload on a channel that is on switches it off within 60 us and sets its prot flag.
// - A channel shut off by protection stays off until software writes 1 to the clear bit.
// - The clear bit drops by itself when the next valid bus frame completes.
// - Over-temperature switches an active channel off and sets its prot flag.
// - Over-temperature also sets the prot flag while the channel is off.
// - A prot flag stays set after its cause goes and is cleared only by the clear bit.
// - An open-load flag stays set until its diagnosis register is read.
// - No open-load detection runs, and the flag holds, while the channel is on.
// - An off channel whose output shows open load gets its flag after the open-load delay.
// - The diagnosis current of a channel flows only while its enable bit is 1.
// - The open-load delay lies between 100 us and 250 us.
// - Four read-only diagnosis registers in bank 1 hold open-load at 3,1 and prot at 2,0.
package cfl_pkg;
    localparam int CFL_NCH         = 8;
    localparam int CFL_CLK_MHZ     = 10;
    localparam int CFL_TICK_CYC    = CFL_CLK_MHZ;   // cycles per 1 us tick
    // overload: documented ceiling and the shorter target used
    localparam int CFL_OVL_MAX_US  = 60;
    localparam int CFL_OVL_OFF_US  = 50;            // margin for sync and tick phase
    localparam int CFL_OVL_MAX_CYC = CFL_OVL_MAX_US * CFL_CLK_MHZ;
    localparam logic [7:0] CFL_OVL_CNT = 8'(CFL_OVL_OFF_US);
    // open-load delay window and the value used
    localparam int CFL_OL_MIN_US   = 100;
    localparam int CFL_OL_MAX_US   = 250;
    localparam int CFL_OL_DLY_US   = 150;
    localparam int CFL_OL_MAX_CYC  = CFL_OL_MAX_US * CFL_CLK_MHZ;
    localparam logic [7:0] CFL_OL_CNT = 8'(CFL_OL_DLY_US);
    // register indices and bank selects
    localparam logic [2:0] CFL_IDX_DR01 = 3'h0;
    localparam logic [2:0] CFL_IDX_DR23 = 3'h1;
    localparam logic [2:0] CFL_IDX_DR45 = 3'h2;
    localparam logic [2:0] CFL_IDX_DR67 = 3'h3;
    localparam logic [2:0] CFL_IDX_CMD  = 3'h6;
    localparam logic [2:0] CFL_IDX_DIAG_CURRENT_CTRL = 3'h7;
    localparam logic       CFL_BANK_DIAG = 1'h1;
    localparam logic       CFL_BANK_CTRL = 1'h0;
    localparam logic [7:0] CFL_ADDR_DR01 = {2'h0, CFL_BANK_DIAG, CFL_IDX_DR01, 2'h0};
    localparam logic [7:0] CFL_ADDR_DR67 = {2'h0, CFL_BANK_DIAG, CFL_IDX_DR67, 2'h0};
    localparam logic [7:0] CFL_ADDR_CMD  = {2'h0, CFL_BANK_CTRL, CFL_IDX_CMD, 2'h0};
    localparam logic [7:0] CFL_ADDR_DIAG_CURRENT_CTRL = {2'h0, CFL_BANK_CTRL, CFL_IDX_DIAG_CURRENT_CTRL, 2'h0};
    localparam int CFL_CPL_BIT = 0;
    localparam logic [7:0] CFL_DIAG_CURRENT_CTRL_RST = 8'h00;
    localparam logic [1:0] CFL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CFL_RESP_SLVERR = 2'h2;
    // analog comparator outputs, one bit per channel each
    typedef struct packed {
        logic [7:0] ovl;    // overload / short
        logic [7:0] otp;    // over-temperature
        logic [7:0] olv;    // off-state output level shows open load
    } cfl_sense_t;
endpackage

// [tb/cfl_bench.sv]
// Purpose: self-checking bench for the channel fault latch
// Assumes: host model runs the bus, bench drives sense levels
// Notes:   open-load wait uses the real delay, about 2500 cycles
`timescale 1ns/100ps
module cfl_bench;
    import cfl_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_nrst, go, h_we, done, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
    logic [7:0] req, ch_on, diag, aw_a, ar_a, h_addr;
    logic [31:0] h_wd, h_rd, wd, rd_b;
    logic [1:0] resp, bresp, rresp;
    logic [3:0] strb;
    cfl_sense_t sense;
    int         error_cnt = 0;
    int         n_compared = 0;

    cfl_top cfl_top_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ch_request(req), .i_sense(sense),
        .o_ch_on(ch_on), .o_diag_current(diag), .i_awvalid(awv), .o_awready(awr),
        .i_awaddr(aw_a), .i_wvalid(wv), .o_wready(wr_r), .i_wdata(wd), .i_wstrb(strb),
        .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
        .i_araddr(ar_a), .o_rvalid(rv), .i_rready(rr), .o_rdata(rd_b), .o_rresp(rresp));
    cfl_host_model cfl_host_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(go), .i_we(h_we),
        .i_addr(h_addr), .i_wdata(h_wd), .o_done(done), .o_rdata(h_rd), .o_resp(resp),
        .o_awvalid(awv), .i_awready(awr), .o_awaddr(aw_a), .o_wvalid(wv), .i_wready(wr_r),
        .o_wdata(wd), .o_wstrb(strb), .i_bvalid(bv), .o_bready(br), .i_bresp(bresp),
        .o_arvalid(arv), .i_arready(arr), .o_araddr(ar_a), .i_rvalid(rv), .o_rready(rr),
        .i_rdata(rd_b), .i_rresp(rresp));

    // 10 MHz clock
    always #50 i_clk = ~i_clk;

    // verdict and end of run
    task automatic results();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        error_cnt++;
        $display("Error at %0t: %s", $time, msg);
    endtask

    // exact four-state compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
            fail($sformatf("%s got %h want %h", what, got, exp));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // one transfer; no fixed latency assumed, only a bounded wait
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp_d, input logic [1:0] exp_r);
        int n;
        n = 0;
        @(posedge i_clk);
        {go, h_we, h_addr, h_wd} <= {1'b1, we, a, d};
        @(posedge i_clk);
        go <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 100)
        begin
            fail("bus timeout");
            results();
        end
        chk({30'h0, resp}, {30'h0, exp_r}, "resp");
        if (!we)
            chk(h_rd, exp_d, "rdata");
    endtask

    task automatic ch_chk(input logic [7:0] exp, input string what);
        @(posedge i_clk);
        #1;
        chk({24'h0, ch_on}, {24'h0, exp}, what);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 4; i++)
            bus(1'b0, CFL_ADDR_DR01 + 8'(4 * i), 32'h0, 32'h0, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_CMD, 32'h0, 32'h0, CFL_RESP_OKAY);
        ch_chk(8'h00, "ch after reset");
    endtask

    // read-only place, unmapped place, diagnosis current enables
    task automatic t_regs();
        bus(1'b1, CFL_ADDR_DR01, 32'hf, 32'h0, CFL_RESP_SLVERR);
        bus(1'b0, 8'h3c, 32'h0, 32'h0, CFL_RESP_SLVERR);
        bus(1'b1, CFL_ADDR_DIAG_CURRENT_CTRL, 32'ha5, 32'h0, CFL_RESP_OKAY);
        chk({24'h0, diag}, 32'ha5, "diag on");
        bus(1'b0, CFL_ADDR_DIAG_CURRENT_CTRL, 32'h0, 32'ha5, CFL_RESP_OKAY);
        bus(1'b1, CFL_ADDR_DIAG_CURRENT_CTRL, 32'h0, 32'h0, CFL_RESP_OKAY);
        chk({24'h0, diag}, 32'h0, "diag off");
    endtask

    // over-temperature on an active channel and on an off one
    task automatic t_prot();
        @(posedge i_clk);
        req <= 8'hdf;
        cyc(4);
        ch_chk(8'hdf, "ch on");
        @(posedge i_clk);
        sense.otp <= 8'h28;
        cyc(4);
        ch_chk(8'hd7, "otp trip");
        @(posedge i_clk);
        sense.otp <= 8'h00;
        cyc(20);
        ch_chk(8'hd7, "latched off");
        bus(1'b0, CFL_ADDR_DR01 + 8'h4, 32'h0, 32'h4, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_DR01 + 8'h8, 32'h0, 32'h4, CFL_RESP_OKAY);
        bus(1'b1, CFL_ADDR_CMD, 32'h1, 32'h0, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_CMD, 32'h0, 32'h1, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_CMD, 32'h0, 32'h0, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_DR01 + 8'h4, 32'h0, 32'h0, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_DR01 + 8'h8, 32'h0, 32'h0, CFL_RESP_OKAY);
        ch_chk(8'hdf, "back on");
    endtask

    // overload must trip within the ceiling
    task automatic t_ovl();
        int n;
        n = 0;
        @(posedge i_clk);
        sense.ovl <= 8'h01;
        @(posedge i_clk);
        #1;
        while (ch_on[0] === 1'b1 && n < 700)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 700)
        begin
            fail("overload wait timeout");
            results();
        end
        chk({31'h0, ch_on[0]}, 32'h0, "ovl trip");
        chk({31'h0, n < CFL_OVL_MAX_CYC}, 32'h1, "ovl delay");
        @(posedge i_clk);
        sense.ovl <= 8'h00;
        bus(1'b0, CFL_ADDR_DR01, 32'h0, 32'h1, CFL_RESP_OKAY);
        bus(1'b1, CFL_ADDR_CMD, 32'h1, 32'h0, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_DR01, 32'h0, 32'h0, CFL_RESP_OKAY);
        ch_chk(8'hdf, "ovl cleared");
    endtask

    // open load on off channel 6 and on active channel 7
    task automatic t_ol();
        @(posedge i_clk);
        req <= 8'h9f;
        sense.olv <= 8'hc0;
        cyc(990);
        bus(1'b0, CFL_ADDR_DR67, 32'h0, 32'h0, CFL_RESP_OKAY);
        cyc(1480);
        sense.olv <= 8'h00;
        bus(1'b0, CFL_ADDR_DR67, 32'h0, 32'h2, CFL_RESP_OKAY);
        bus(1'b0, CFL_ADDR_DR67, 32'h0, 32'h0, CFL_RESP_OKAY);
    endtask

    // a reset in mid-run wipes a set flag
    task automatic t_rst2();
        @(posedge i_clk);
        sense.otp <= 8'h01;
        cyc(6);
        sense.otp <= 8'h00;
        bus(1'b0, CFL_ADDR_DR01, 32'h0, 32'h1, CFL_RESP_OKAY);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        cyc(16);
        i_nrst <= 1'b1;
        cyc(4);
        bus(1'b0, CFL_ADDR_DR01, 32'h0, 32'h0, CFL_RESP_OKAY);
        ch_chk(8'h9f, "ch after mid reset");
    endtask

    // main sequence
    initial
    begin
        {i_nrst, req, go, h_we, h_addr, h_wd} = '0;
        sense = '0;
        cyc(16);
        i_nrst <= 1'b1;
        cyc(4);
        t_reset();
        t_regs();
        t_prot();
        t_ovl();
        t_ol();
        t_rst2();
        results();
    end

    // hang guard
    initial
    begin
        #(100 * 20000);
        fail("run timeout");
        results();
    end
endmodule

// [tb/cfl_host_model.sv]
// Purpose: host model that runs single AXI4-Lite reads and writes
// Assumes: one request at a time, given while no transfer is busy
// Notes:   released payload is inverted so a late sample shows up
`timescale 1ns/100ps
module cfl_host_model
(
    input  wire logic        i_clk,     // clock
    input  wire logic        i_nrst,    // reset, active low
    input  wire logic        i_go,      // start a transfer
    input  wire logic        i_we,      // 1 write, 0 read
    input  wire logic [7:0]  i_addr,    // byte address
    input  wire logic [31:0] i_wdata,   // data to write
    output logic             o_done,    // one-cycle finish pulse
    output logic      [31:0] o_rdata,   // data read
    output logic      [1:0]  o_resp,    // response code
    output logic             o_awvalid, // aw valid
    input  wire logic        i_awready, // aw ready
    output logic      [7:0]  o_awaddr,  // aw address
    output logic             o_wvalid,  // w valid
    input  wire logic        i_wready,  // w ready
    output logic      [31:0] o_wdata,   // w data
    output logic      [3:0]  o_wstrb,   // w strobes
    input  wire logic        i_bvalid,  // b valid
    output logic             o_bready,  // b ready
    input  wire logic [1:0]  i_bresp,   // b response
    output logic             o_arvalid, // ar valid
    input  wire logic        i_arready, // ar ready
    output logic      [7:0]  o_araddr,  // ar address
    input  wire logic        i_rvalid,  // r valid
    output logic             o_rready,  // r ready
    input  wire logic [31:0] i_rdata,   // r data
    input  wire logic [1:0]  i_rresp    // r response
);
    logic busy; // a transfer is under way

    // each channel holds until its own handshake, then lets go
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            {busy, o_done, o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} <= '0;
            {o_rdata, o_resp, o_awaddr, o_wdata, o_wstrb, o_araddr} <= '0;
        end
        else
        begin
            o_done <= 1'b0;
            if (!busy && i_go)
            begin
                busy <= 1'b1;
                {o_awvalid, o_wvalid, o_bready} <= {3{i_we}};
                {o_arvalid, o_rready} <= {2{!i_we}};
                {o_awaddr, o_araddr} <= {i_addr, i_addr};
                o_wdata <= i_wdata;
                o_wstrb <= 4'hf;
            end
            if (o_awvalid && i_awready)
                {o_awvalid, o_awaddr} <= {1'b0, ~o_awaddr};
            if (o_wvalid && i_wready)
                {o_wvalid, o_wdata} <= {1'b0, ~o_wdata};
            if (o_arvalid && i_arready)
                {o_arvalid, o_araddr} <= {1'b0, ~o_araddr};
            if (o_bready && i_bvalid)
                {o_bready, o_resp, busy, o_done} <= {1'b0, i_bresp, 2'h1};
            if (o_rready && i_rvalid)
                {o_rready, o_rdata, o_resp, busy, o_done} <= {1'b0, i_rdata, i_rresp, 2'h1};
        end
    end
endmodule

// [verilog/cfl_sync.sv]
// Purpose: two-flop synchroniser for a vector of level inputs
// Assumes: each bit is an independent slow level
// Notes:   first stage is read by the second stage only
`timescale 1ns/100ps
module cfl_sync
#(
    parameter int W = 24
)(
    input  wire logic         i_clk,   // system clock
    input  wire logic         i_nrst,  // synchronised reset, active low
    input  wire logic [W-1:0] i_d,     // asynchronous levels
    output logic      [W-1:0] o_q      // synchronised levels
);
    logic [W-1:0] meta;

    // bits may skew by a cycle against each other; each is used alone
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta <= '0;
            o_q  <= '0;
        end
        else
        begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

// [verilog/cfl_tick.sv]
// Purpose: divider giving a one-cycle enable every CYC clocks
// Assumes: CYC of at least 2
// Notes:   free running from reset release
`timescale 1ns/100ps
module cfl_tick
#(
    parameter int CYC = 10
)(
    input  wire logic i_clk,   // system clock
    input  wire logic i_nrst,  // synchronised reset, active low
    output logic      o_tick   // one-cycle pulse
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_tick;

    // count down and pulse on wrap
    always_comb
    begin
        next_tick = (cnt == 8'h00);
        next_cnt  = next_tick ? 8'(CYC - 1) : cnt - 8'h01;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt    <= 8'h00;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule

// [verilog/cfl_top.sv]
// Purpose: per-channel protection latches and open-load diagnosis
// Assumes: channel requests come from the input multiplexer outside
// Notes:   registers over AXI4-Lite; a bus frame is one B or R handshake
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module cfl_top
    import cfl_pkg::*;
(
    input  wire logic        i_clk,          // 10 MHz clock
    input  wire logic        i_nrst,         // async reset, active low
    input  wire logic [7:0]  i_ch_request,   // channel wants to be on
    input  wire cfl_sense_t  i_sense,        // analog comparator levels
    output logic      [7:0]  o_ch_on,        // power stage gate enable
    output logic      [7:0]  o_diag_current, // diagnosis current source on
    input  wire logic        i_awvalid,      // write address valid
    output logic             o_awready,      // write address ready
    input  wire logic [7:0]  i_awaddr,       // write byte address
    input  wire logic        i_wvalid,       // write data valid
    output logic             o_wready,       // write data ready
    input  wire logic [31:0] i_wdata,        // write data
    input  wire logic [3:0]  i_wstrb,        // byte strobes
    output logic             o_bvalid,       // write response valid
    input  wire logic        i_bready,       // write response ready
    output logic      [1:0]  o_bresp,        // write response
    input  wire logic        i_arvalid,      // read address valid
    output logic             o_arready,      // read address ready
    input  wire logic [7:0]  i_araddr,       // read byte address
    output logic             o_rvalid,       // read data valid
    input  wire logic        i_rready,       // read data ready
    output logic      [31:0] o_rdata,        // read data
    output logic      [1:0]  o_rresp         // read response
);
    logic [1:0]  rst_q;
    logic        rst_n;
    cfl_sense_t  sense;
    logic        tick;
    logic        aw_held, w_held;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_wdata, next_rdata;
    logic [3:0]  next_wstrb;
    logic [1:0]  next_bresp, next_rresp;
    logic        wr_go, wr_ok, rd_take, wr_done, rd_done;
    logic        clear_protection_latch, cpl_fresh, next_cpl, next_cpl_fresh;
    logic [7:0]  dcen, next_dcen;
    logic [7:0]  pf, ol, on, ol_set, ol_rdclr;
    logic [31:0] rd_word;
    logic        rd_ok;

    // reset release through two flops; assert stays asynchronous
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // comparator levels are unrelated to the clock
    cfl_sync #(
        .W ($bits(cfl_sense_t))
    ) u_sync (
        .i_clk  (i_clk),
        .i_nrst (rst_n),
        .i_d    (i_sense),
        .o_q    (sense)
    );

    // 1 us enable for the delay counters, keeps them 8 bits wide
    cfl_tick #(
        .CYC (CFL_TICK_CYC)
    ) u_tick (
        .i_clk  (i_clk),
        .i_nrst (rst_n),
        .o_tick (tick)
    );

    // write channel: address and data taken in either order
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_wdata   = wdata;
        next_wstrb   = wstrb;
        next_bvalid  = o_bvalid;
        next_bresp   = o_bresp;
        wr_go        = aw_held & w_held & ~o_bvalid;
        wr_ok        = (aw_addr == CFL_ADDR_CMD) | (aw_addr == CFL_ADDR_DIAG_CURRENT_CTRL);
        wr_done      = o_bvalid & i_bready;
        if (o_awready && i_awvalid)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = i_awaddr;
        end
        if (o_wready && i_wvalid)
        begin
            next_w_held = 1'b1;
            next_wdata  = i_wdata;
            next_wstrb  = i_wstrb;
        end
        if (wr_done)
            next_bvalid = 1'b0;
        if (wr_go)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_ok ? CFL_RESP_OKAY : CFL_RESP_SLVERR;
        end
    end

    // read mux: diagnosis pairs, command and current enables
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (i_araddr[7:2])
            {2'h0, CFL_BANK_DIAG, CFL_IDX_DR01},
            {2'h0, CFL_BANK_DIAG, CFL_IDX_DR23},
            {2'h0, CFL_BANK_DIAG, CFL_IDX_DR45},
            {2'h0, CFL_BANK_DIAG, CFL_IDX_DR67}:
                rd_word[3:0] = {ol[{i_araddr[3:2], 1'b1}], pf[{i_araddr[3:2], 1'b1}],
                                ol[{i_araddr[3:2], 1'b0}], pf[{i_araddr[3:2], 1'b0}]};
            CFL_ADDR_CMD[7:2]:
                rd_word[CFL_CPL_BIT] = clear_protection_latch;
            CFL_ADDR_DIAG_CURRENT_CTRL[7:2]:
                rd_word[7:0] = dcen;
            default:
                rd_ok = 1'b0;
        endcase
    end

    // read channel: one read in flight, data sampled at the handshake
    always_comb
    begin
        next_rvalid = o_rvalid;
        next_rdata  = o_rdata;
        next_rresp  = o_rresp;
        rd_take     = o_arready & i_arvalid;
        rd_done     = o_rvalid & i_rready;
        if (rd_done)
            next_rvalid = 1'b0;
        if (rd_take)
        begin
            next_rvalid = 1'b1;
            next_rdata  = rd_word;
            next_rresp  = rd_ok ? CFL_RESP_OKAY : CFL_RESP_SLVERR;
        end
    end

    // reading a diagnosis register clears its two open-load flags
    always_comb
    begin
        ol_rdclr = 8'h00;
        if (rd_take && i_araddr[7:4] == CFL_ADDR_DR01[7:4])
            ol_rdclr[{i_araddr[3:2], 1'b0} +: 2] = 2'h3;
    end

    // command and current-enable registers
    always_comb
    begin
        next_cpl       = clear_protection_latch;
        next_cpl_fresh = cpl_fresh;
        next_dcen      = dcen;
        // the frame that wrote the bit does not count as the next one
        if (rd_done || (wr_done && !cpl_fresh))
            next_cpl = 1'b0;
        if (wr_done)
            next_cpl_fresh = 1'b0;
        if (wr_go && wstrb[0] && aw_addr == CFL_ADDR_CMD)
        begin
            next_cpl       = wdata[CFL_CPL_BIT];
            next_cpl_fresh = wdata[CFL_CPL_BIT];
        end
        if (wr_go && wstrb[0] && aw_addr == CFL_ADDR_DIAG_CURRENT_CTRL)
            next_dcen = wdata[7:0];
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held   <= 1'b0;
            aw_addr   <= 8'h00;
            w_held    <= 1'b0;
            wdata     <= 32'h0000_0000;
            wstrb     <= 4'h0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= CFL_RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= CFL_RESP_OKAY;
            clear_protection_latch       <= 1'b0;
            cpl_fresh <= 1'b0;
            dcen      <= CFL_DIAG_CURRENT_CTRL_RST;
        end
        else
        begin
            aw_held   <= next_aw_held;
            aw_addr   <= next_aw_addr;
            w_held    <= next_w_held;
            wdata     <= next_wdata;
            wstrb     <= next_wstrb;
            o_awready <= ~next_aw_held;
            o_wready  <= ~next_w_held;
            o_bvalid  <= next_bvalid;
            o_bresp   <= next_bresp;
            o_arready <= ~next_rvalid;
            o_rvalid  <= next_rvalid;
            o_rdata   <= next_rdata;
            o_rresp   <= next_rresp;
            clear_protection_latch       <= next_cpl;
            cpl_fresh <= next_cpl_fresh;
            dcen      <= next_dcen;
        end
    end

    assign o_diag_current = dcen;
    assign o_ch_on        = on;

    // per-channel protection latch and open-load detector
    for (genvar i = 0; i < CFL_NCH; i++)
    begin : g_ch
        logic [7:0] ovl_cnt, ol_cnt, next_ovl_cnt, next_ol_cnt;
        logic       next_pf, next_ol, next_on, ovl_trip;
        logic [11:0] ol_wait, next_ol_wait; // cycles in the open-load condition, checks only

        always_comb
        begin
            // overload only counts while the stage conducts
            next_ovl_cnt = 8'h00;
            if (sense.ovl[i] && on[i])
                next_ovl_cnt = (tick && ovl_cnt != CFL_OVL_CNT) ? ovl_cnt + 8'h01 : ovl_cnt;
            ovl_trip = sense.ovl[i] & on[i] & (ovl_cnt == CFL_OVL_CNT);
            // detection is idle while on
            next_ol_cnt = 8'h00;
            if (!on[i] && sense.olv[i])
                next_ol_cnt = (tick && ol_cnt != CFL_OL_CNT) ? ol_cnt + 8'h01 : ol_cnt;
            ol_set[i] = ~on[i] & sense.olv[i] & (ol_cnt == CFL_OL_CNT);
            next_ol_wait = (ol_wait == 12'hfff) ? ol_wait : ol_wait + 12'h001;  // saturates
            if (on[i] || !sense.olv[i])
                next_ol_wait = 12'h000;
            // setting beats the clear in the same cycle
            next_pf = pf[i] & ~clear_protection_latch;
            if (ovl_trip || sense.otp[i])
                next_pf = 1'b1;
            next_ol = ol[i] & ~ol_rdclr[i];
            if (ol_set[i])
                next_ol = 1'b1;
            next_on = i_ch_request[i] & ~next_pf;
        end

        always_ff @(posedge i_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ovl_cnt <= 8'h00;
                ol_cnt  <= 8'h00;
                ol_wait <= 12'h000;
                pf[i]   <= 1'b0;
                ol[i]   <= 1'b0;
                on[i]   <= 1'b0;
            end
            else
            begin
                ovl_cnt <= next_ovl_cnt;
                ol_cnt  <= next_ol_cnt;
                ol_wait <= next_ol_wait;
                pf[i]   <= next_pf;
                ol[i]   <= next_ol;
                on[i]   <= next_on;
            end
        end

        a_ovl_shutoff: assert property (@(posedge i_clk) disable iff (!rst_n)
            on[i] && sense.ovl[i] |-> ##[1:600] (!sense.ovl[i] || (pf[i] && !on[i])))
            else $error("overload not shut off in time");
        a_prot_stays_off: assert property (@(posedge i_clk) disable iff (!rst_n)
            pf[i] && !clear_protection_latch |=> !on[i] ##1 (!on[i] || $past(clear_protection_latch, 2) || !pf[i]))
            else $error("channel on while protection latched");
        a_otp_switch_off: assert property (@(posedge i_clk) disable iff (!rst_n)
            sense.otp[i] |=> !on[i] && pf[i])
            else $error("over-temperature did not switch off");
        a_otp_off_state: assert property (@(posedge i_clk) disable iff (!rst_n)
            !on[i] && !i_ch_request[i] && sense.otp[i] |=> pf[i])
            else $error("over-temperature flag not set while off");
        a_prot_latched: assert property (@(posedge i_clk) disable iff (!rst_n)
            pf[i] && !clear_protection_latch |=> pf[i])
            else $error("prot flag lost without clear");
        a_ol_read_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
            ol_rdclr[i] && !ol_set[i] |=> !ol[i])
            else $error("open-load flag not cleared by read");
        a_ol_on_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
            on[i] && !ol_rdclr[i] |=> $stable(ol[i]))
            else $error("open-load flag changed while on");
        a_ol_delay_max: assert property (@(posedge i_clk) disable iff (!rst_n)
            ol_wait >= 12'(CFL_OL_MAX_CYC) |-> ol[i])
            else $error("open-load flag late");
        a_ol_delay_min: assert property (@(posedge i_clk) disable iff (!rst_n)
            $rose(ol_set[i]) |-> ol_wait >= 12'(CFL_OL_MIN_US * CFL_CLK_MHZ))
            else $error("open-load flag early");
    end

    sequence s_cpl_written;
        wr_go && wstrb[0] && aw_addr == CFL_ADDR_CMD && wdata[CFL_CPL_BIT];
    endsequence
    sequence s_next_frame;
        !cpl_fresh && clear_protection_latch && (rd_done || wr_done) && !wr_go;
    endsequence

    a_cpl_self_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_next_frame |=> !clear_protection_latch)
        else $error("clear bit survived the next frame");
    a_cpl_own_frame: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_cpl_written |=> clear_protection_latch ##1 (clear_protection_latch || $past(rd_done)))
        else $error("clear bit dropped by its own frame");
    a_diag_enable: assert property (@(posedge i_clk) disable iff (!rst_n)
        wr_go && wstrb[0] && aw_addr == CFL_ADDR_DIAG_CURRENT_CTRL |=> o_diag_current == $past(wdata[7:0]))
        else $error("diagnosis current does not follow its enable");
    a_diag_map: assert property (@(posedge i_clk) disable iff (!rst_n)
        rd_take && i_araddr == CFL_ADDR_DR67
        |=> o_rvalid && o_rdata == {28'h0, $past(ol[7]), $past(pf[7]), $past(ol[6]), $past(pf[6])})
        else $error("diagnosis register layout wrong");
endmodule
